// ===== logic/tcps_top.v
// timer clock prescale select with axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "tcps_consts.vh"
module tcps_top #(
	parameter integer ADDR_W    = 12,
	parameter integer PRE_DIV0  = 12,
	parameter integer PRE_DIV1  = 4,
	parameter integer PRE_DIV2  = 48
) (
	// clock and reset
	input  wire              ref_clk_i,
	input  wire              reset_i,
	// external oscillator clock pin
	input  wire              ext_osc_clk_i,
	// axi4-lite write address
	input  wire [ADDR_W-1:0] s_axi_awaddr_i,
	input  wire              s_axi_awvalid_i,
	output wire              s_axi_awready_o,
	// axi4-lite write data
	input  wire [31:0]       s_axi_wdata_i,
	input  wire [3:0]        s_axi_wstrb_i,
	input  wire              s_axi_wvalid_i,
	output wire              s_axi_wready_o,
	// axi4-lite write response
	output reg  [1:0]        s_axi_bresp_o,
	output reg               s_axi_bvalid_o,
	input  wire              s_axi_bready_i,
	// axi4-lite read address
	input  wire [ADDR_W-1:0] s_axi_araddr_i,
	input  wire              s_axi_arvalid_i,
	output wire              s_axi_arready_o,
	// axi4-lite read data
	output reg  [31:0]       s_axi_rdata_o,
	output reg  [1:0]        s_axi_rresp_o,
	output reg               s_axi_rvalid_o,
	input  wire              s_axi_rready_i,
	// timer count ticks
	output reg               timer0_tick_o,
	output reg               timer1_tick_o,
	output reg               timer2_low_tick_o,
	output reg               timer2_high_tick_o,
	output reg               timer3_low_tick_o,
	output reg               timer3_high_tick_o,
	// timer 0 low count
	output wire [7:0]        timer0_count_low_o
);
	// ==========================================
	// registers
	reg  [7:0]        timer_clock_prescale_ctrl;
	reg  [7:0]        timer0_count_low;
	reg  [7:0]        alt_select_ctrl;
	wire [1:0]        prescale_select_field;
	wire              timer0_clock_select;
	wire              timer1_clock_select;
	wire              timer2_low_clock_select;
	wire              timer2_high_clock_select;
	wire              timer3_low_clock_select;
	wire              timer3_high_clock_select;
	wire              timer2_alt_source_select;
	wire              timer3_alt_source_select;
	wire              timer0_run;
	assign prescale_select_field =
		timer_clock_prescale_ctrl[`TCPS_PRESCALE_MSB:`TCPS_PRESCALE_LSB];
	assign timer0_clock_select      = timer_clock_prescale_ctrl[`TCPS_T0_SEL_BIT];
	assign timer1_clock_select      = timer_clock_prescale_ctrl[`TCPS_T1_SEL_BIT];
	assign timer2_low_clock_select  = timer_clock_prescale_ctrl[`TCPS_T2L_SEL_BIT];
	assign timer2_high_clock_select = timer_clock_prescale_ctrl[`TCPS_T2H_SEL_BIT];
	assign timer3_low_clock_select  = timer_clock_prescale_ctrl[`TCPS_T3L_SEL_BIT];
	assign timer3_high_clock_select = timer_clock_prescale_ctrl[`TCPS_T3H_SEL_BIT];
	assign timer2_alt_source_select = alt_select_ctrl[`TCPS_T2_ALT_BIT];
	assign timer3_alt_source_select = alt_select_ctrl[`TCPS_T3_ALT_BIT];
	assign timer0_run               = alt_select_ctrl[`TCPS_T0_RUN_BIT];
	assign timer0_count_low_o       = timer0_count_low;
	// ==========================================
	// address decode, shared by read and write
	localparam [1:0] SEL_NONE = 2'd0;
	localparam [1:0] SEL_CTRL = 2'd1;
	localparam [1:0] SEL_T0LO = 2'd2;
	localparam [1:0] SEL_ALT  = 2'd3;
	function [1:0] tcps_decode;
		input [ADDR_W-1:0] addr;
		begin
			if (addr[ADDR_W-1:2] == `TCPS_CTRL_IDX)
				tcps_decode = SEL_CTRL;
			else if (addr[ADDR_W-1:2] == `TCPS_T0LOW_IDX)
				tcps_decode = SEL_T0LO;
			else if (addr[ADDR_W-1:2] == `TCPS_ALTSEL_IDX)
				tcps_decode = SEL_ALT;
			else
				tcps_decode = SEL_NONE;
		end
	endfunction
	// ==========================================
	// write channel: address and data taken in either order
	reg              aw_held;
	reg              w_held;
	reg [ADDR_W-1:0] aw_addr;
	reg [7:0]        w_byte;
	reg              w_lane0;
	wire             do_write;
	wire [1:0]       wsel;
	assign s_axi_awready_o = ~aw_held & ~s_axi_bvalid_o;
	assign s_axi_wready_o  = ~w_held & ~s_axi_bvalid_o;
	assign do_write        = aw_held & w_held & ~s_axi_bvalid_o;
	assign wsel            = tcps_decode(aw_addr);
	always @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= {ADDR_W{1'b0}};
			w_byte <= 8'h00;
			w_lane0 <= 1'b0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= `TCPS_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid_i && s_axi_awready_o)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o)
			begin
				w_held <= 1'b1;
				w_byte <= s_axi_wdata_i[7:0];
				w_lane0 <= s_axi_wstrb_i[0];
			end
			if (do_write)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= (wsel == SEL_NONE) ?
					`TCPS_RESP_SLVERR : `TCPS_RESP_OKAY;
			end
			else if (s_axi_bvalid_o && s_axi_bready_i)
			begin
				s_axi_bvalid_o <= 1'b0;
			end
		end
	end
	wire wr_ctrl = do_write & w_lane0 & (wsel == SEL_CTRL);
	wire wr_t0lo = do_write & w_lane0 & (wsel == SEL_T0LO);
	wire wr_alt  = do_write & w_lane0 & (wsel == SEL_ALT);
	// ==========================================
	// read channel
	wire [1:0] rsel = tcps_decode(s_axi_araddr_i);
	assign s_axi_arready_o = ~s_axi_rvalid_o;
	always @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0000_0000;
			s_axi_rresp_o <= `TCPS_RESP_OKAY;
		end
		else if (s_axi_arvalid_i && s_axi_arready_o)
		begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rresp_o <= `TCPS_RESP_OKAY;
			if (rsel == SEL_CTRL)
				s_axi_rdata_o <= {24'h00_0000, timer_clock_prescale_ctrl};
			else if (rsel == SEL_T0LO)
				s_axi_rdata_o <= {24'h00_0000, timer0_count_low};
			else if (rsel == SEL_ALT)
				s_axi_rdata_o <= {24'h00_0000, alt_select_ctrl};
			else
			begin
				s_axi_rdata_o <= 32'h0000_0000;
				s_axi_rresp_o <= `TCPS_RESP_SLVERR;
			end
		end
		else if (s_axi_rvalid_o && s_axi_rready_i)
		begin
			s_axi_rvalid_o <= 1'b0;
		end
	end
	// ==========================================
	// control registers
	always @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			timer_clock_prescale_ctrl <= `TCPS_CTRL_RST;
			alt_select_ctrl <= `TCPS_ALTSEL_RST;
		end
		else
		begin
			if (wr_ctrl)
				timer_clock_prescale_ctrl <= w_byte;
			if (wr_alt)
				alt_select_ctrl <= w_byte & `TCPS_ALTSEL_MASK;
		end
	end
	// ==========================================
	// external clock sync, edge detect, divide by eight
	reg  ext_meta;
	reg  ext_sync;
	reg  ext_last;
	wire ext_rise;
	wire ext8_tick;
	always @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
			ext_last <= 1'b0;
		end
		else
		begin
			ext_meta <= ext_osc_clk_i;
			ext_sync <= ext_meta;
			ext_last <= ext_sync;
		end
	end
	assign ext_rise = ext_sync & ~ext_last;
	// only edges slower than half the system clock are seen
	tcps_divider #(.DIV(`TCPS_EXT_DIV), .WIDTH(3)) u_ext8 (
		.ref_clk_i (ref_clk_i),
		.reset_i   (reset_i),
		.enable_i  (ext_rise),
		.tick_o    (ext8_tick)
	);
	// ==========================================
	// system clock dividers
	wire alt12_tick;
	wire [2:0] pre_ticks;
	genvar     g;
	tcps_divider #(.DIV(`TCPS_ALT_DIV), .WIDTH(4)) u_alt12 (
		.ref_clk_i (ref_clk_i),
		.reset_i   (reset_i),
		.enable_i  (1'b1),
		.tick_o    (alt12_tick)
	);
	generate
		for (g = 0; g < 3; g = g + 1)
		begin : pre_div
			tcps_divider #(.WIDTH(8),
				.DIV(g == 0 ? PRE_DIV0 : g == 1 ? PRE_DIV1 : PRE_DIV2)) u_pre (
				.ref_clk_i (ref_clk_i),
				.reset_i   (reset_i),
				.enable_i  (1'b1),
				.tick_o    (pre_ticks[g])
			);
		end
	endgenerate
	// ==========================================
	// clock selection
	reg  pre_tick;
	wire t2_alt_tick;
	wire t3_alt_tick;
	always @*
	begin
		case (prescale_select_field)
			`TCPS_PRE_DIV0: pre_tick = pre_ticks[0];
			`TCPS_PRE_DIV1: pre_tick = pre_ticks[1];
			`TCPS_PRE_DIV2: pre_tick = pre_ticks[2];
			default:        pre_tick = ext8_tick;
		endcase
	end
	assign t2_alt_tick = timer2_alt_source_select ? ext8_tick : alt12_tick;
	assign t3_alt_tick = timer3_alt_source_select ? ext8_tick : alt12_tick;
	always @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			timer0_tick_o <= 1'b0;
			timer1_tick_o <= 1'b0;
			timer2_low_tick_o <= 1'b0;
			timer2_high_tick_o <= 1'b0;
			timer3_low_tick_o <= 1'b0;
			timer3_high_tick_o <= 1'b0;
		end
		else
		begin
			timer0_tick_o <= timer0_clock_select | pre_tick;
			timer1_tick_o <= timer1_clock_select | pre_tick;
			timer2_low_tick_o <= timer2_low_clock_select | t2_alt_tick;
			timer2_high_tick_o <= timer2_high_clock_select | t2_alt_tick;
			timer3_low_tick_o <= timer3_low_clock_select | t3_alt_tick;
			timer3_high_tick_o <= timer3_high_clock_select | t3_alt_tick;
		end
	end
	// ==========================================
	// timer 0 low count, software write beats a tick
	always @(posedge ref_clk_i)
	begin
		if (reset_i)
			timer0_count_low <= `TCPS_T0LOW_RST;
		else if (wr_t0lo)
			timer0_count_low <= w_byte;
		else if (timer0_run && timer0_tick_o)
			timer0_count_low <= timer0_count_low + 8'h01;
	end
endmodule
`default_nettype wire

// ===== logic/tcps_consts.vh
// constants for the timer clock prescale select block
// Function
// - two-bit prescale field picks the shared divided clock for timers 0 and 1
// - prescale field 11 gives the external oscillator clock divided by eight
// - external divide-by-eight path is synchronised to the system clock first
// - timer 0 low count byte is software read/write and resets to zero
// - timer 2 halves count system/12, external/8, or system clock as selected
`ifndef TCPS_CONSTS_VH
`define TCPS_CONSTS_VH
// ==========================================
// register indices, byte address is four times the index
`define TCPS_CTRL_IDX        10'h08e
`define TCPS_T0LOW_IDX       10'h08a
`define TCPS_ALTSEL_IDX      10'h090
// ==========================================
// reset values
`define TCPS_CTRL_RST        8'h00
`define TCPS_T0LOW_RST       8'h00
`define TCPS_ALTSEL_RST      8'h00
// ==========================================
// control register fields
`define TCPS_PRESCALE_LSB    0
`define TCPS_PRESCALE_MSB    1
`define TCPS_T0_SEL_BIT      2
`define TCPS_T1_SEL_BIT      3
`define TCPS_T2L_SEL_BIT     4
`define TCPS_T2H_SEL_BIT     5
`define TCPS_T3L_SEL_BIT     6
`define TCPS_T3H_SEL_BIT     7
// alternate-source register fields
`define TCPS_T2_ALT_BIT      0
`define TCPS_T3_ALT_BIT      1
`define TCPS_T0_RUN_BIT      2
`define TCPS_ALTSEL_MASK     8'h07
// ==========================================
// prescale field codes
`define TCPS_PRE_DIV0        2'h0
`define TCPS_PRE_DIV1        2'h1
`define TCPS_PRE_DIV2        2'h2
`define TCPS_PRE_EXT8        2'h3
// ==========================================
// fixed divisions
`define TCPS_ALT_DIV         12
`define TCPS_EXT_DIV         8
// ==========================================
// axi responses
`define TCPS_RESP_OKAY       2'h0
`define TCPS_RESP_SLVERR     2'h2
`endif

// ===== logic/tcps_divider.v
// enabled modulo counter emitting a one-cycle tick each wrap
`timescale 1ns/1ps
`default_nettype none
module tcps_divider #(
	parameter integer DIV   = 12,
	parameter integer WIDTH = 8
) (
	// clock and reset
	input  wire             ref_clk_i,
	input  wire             reset_i,
	// count enable and tick
	input  wire             enable_i,
	output reg              tick_o
);
	localparam integer     LAST_INT = DIV - 1;
	localparam [WIDTH-1:0] LAST     = LAST_INT[WIDTH-1:0];
	reg [WIDTH-1:0] count;
	always @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			count <= {WIDTH{1'b0}};
			tick_o <= 1'b0;
		end
		else if (enable_i)
		begin
			if (count == LAST)
			begin
				count <= {WIDTH{1'b0}};
				tick_o <= 1'b1;
			end
			else
			begin
				count <= count + 1'b1;
				tick_o <= 1'b0;
			end
		end
		else
		begin
			tick_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== bench/tcps_top_asserts.sv
// assertion checker for the timer clock prescale select block
`timescale 1ns/1ps
`default_nettype none
`include "tcps_consts.vh"
module tcps_chk #(
	parameter integer ADDR_W = 12
) (
	// clock and reset
	input wire logic              ref_clk_i,
	input wire logic              reset_i,
	// register bus
	input wire logic              s_axi_awready_o,
	input wire logic              s_axi_wready_o,
	input wire logic [1:0]        s_axi_bresp_o,
	input wire logic              s_axi_bvalid_o,
	input wire logic              s_axi_bready_i,
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic              s_axi_arvalid_i,
	input wire logic              s_axi_arready_o,
	input wire logic [31:0]       s_axi_rdata_o,
	input wire logic [1:0]        s_axi_rresp_o,
	input wire logic              s_axi_rvalid_o,
	input wire logic              s_axi_rready_i,
	// timer 0
	input wire logic              timer0_tick_o,
	input wire logic [7:0]        timer0_count_low_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = a == {`TCPS_CTRL_IDX, 2'h0} || a == {`TCPS_T0LOW_IDX, 2'h0}
			|| a == {`TCPS_ALTSEL_IDX, 2'h0};
	endfunction
	sequence rd_take;
		s_axi_arvalid_i && s_axi_arready_o;
	endsequence
	sequence rd_ans;
		s_axi_rvalid_o;
	endsequence
	// ==========================================
	// bus handshakes
	bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
		s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("bresp dropped");
	rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
		s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("rdata dropped");
	aw_refuse_a: assert property (s_axi_bvalid_o |->
		!s_axi_awready_o && !s_axi_wready_o) else $error("write taken early");
	ar_refuse_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read taken early");
	rresp_map_a: assert property (rd_take |=> rd_ans ##0 s_axi_rresp_o ==
		(mapped($past(s_axi_araddr_i)) ? `TCPS_RESP_OKAY : `TCPS_RESP_SLVERR))
		else $error("bad read response");
	// ==========================================
	// read data upper bits and count byte
	rdata_upper_a: assert property (s_axi_rvalid_o |->
		s_axi_rdata_o[31:8] == 24'h00_0000) else $error("upper bits set");
	reset_quiet_a: assert property ($fell(reset_i) |->
		!s_axi_bvalid_o && !s_axi_rvalid_o && timer0_count_low_o == 8'h00)
		else $error("not quiet after reset");
	// a write lands on the edge that raises bvalid, so either cause is legal
	count_step_a: assert property ($changed(timer0_count_low_o) |->
		$rose(s_axi_bvalid_o) || ($past(timer0_tick_o) &&
		timer0_count_low_o == $past(timer0_count_low_o) + 8'h01))
		else $error("count moved without cause");
endmodule
bind tcps_top tcps_chk #(.ADDR_W(ADDR_W)) tcps_chk_i (.ref_clk_i(ref_clk_i),
	.reset_i(reset_i), .s_axi_awready_o(s_axi_awready_o),
	.s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
	.s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
	.s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
	.s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
	.s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
	.s_axi_rready_i(s_axi_rready_i), .timer0_tick_o(timer0_tick_o),
	.timer0_count_low_o(timer0_count_low_o));
`default_nettype wire

// ===== bench/tb_tcps_top.sv
// self-checking bench for the timer clock prescale select block
`timescale 1ns/1ps
`default_nettype none
`include "tcps_consts.vh"
module tb_tcps_top;
	localparam logic [11:0] A_CTL = {`TCPS_CTRL_IDX, 2'h0};
	localparam logic [11:0] A_T0  = {`TCPS_T0LOW_IDX, 2'h0};
	localparam logic [11:0] A_ALT = {`TCPS_ALTSEL_IDX, 2'h0};
	localparam logic [1:0]  OK    = `TCPS_RESP_OKAY;
	localparam logic [1:0]  ER    = `TCPS_RESP_SLVERR;
	logic        clk     = 1'b0;
	logic        rst     = 1'b1;
	logic        ext     = 1'b0;
	logic        ext_run = 1'b0;
	logic [1:0]  ediv    = 2'h0;
	logic [11:0] awaddr  = 12'h000;
	logic [11:0] araddr  = 12'h000;
	logic [31:0] wdata   = 32'h0000_0000;
	logic        awvalid = 1'b0;
	logic        wvalid  = 1'b0;
	logic        bready  = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready  = 1'b0;
	logic [3:0]  strb    = 4'h1;
	wire         awready, wready, bvalid, arready, rvalid;
	wire [1:0]   bresp, rresp;
	wire [31:0]  rdata;
	wire [5:0]   tk;
	wire [7:0]   cnt0;
	int          err_total    = 0;
	int          total_checks = 0;
	int          cyc          = 0;
	logic [31:0] cnt [6];
	initial
		forever #2.5 clk = ~clk;
	// small divisions keep the windows short
	tcps_top #(.PRE_DIV0(2), .PRE_DIV1(3), .PRE_DIV2(4)) tcps_top_i (
		.ref_clk_i(clk), .reset_i(rst), .ext_osc_clk_i(ext),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(strb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .timer0_tick_o(tk[0]),
		.timer1_tick_o(tk[1]), .timer2_low_tick_o(tk[2]),
		.timer2_high_tick_o(tk[3]), .timer3_low_tick_o(tk[4]),
		.timer3_high_tick_o(tk[5]), .timer0_count_low_o(cnt0));
	// ==========================================
	// oscillator of period eight cycles, and the timeout
	always @(posedge clk)
	begin
		ediv <= ediv + 2'h1;
		if (ext_run && ediv == 2'h3)
			ext <= ~ext;
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_total++;
			$display("mismatch at %0t: timeout", $time);
			finish_test;
		end
	end
	task automatic finish_test;
	begin
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	end
	endtask
	task automatic chk_ticks(input int e0, e1, e2, e3, e4, e5);
	int e [6];
	begin
		e = '{e0, e1, e2, e3, e4, e5};
		for (int i = 0; i < 6; i++)
			chk(cnt[i], e[i]);
	end
	endtask
	// ==========================================
	// bus cycles
	task automatic wr(input logic [11:0] a, input logic [7:0] d,
		input logic [1:0] er);
	begin
		awaddr <= a;
		wdata <= {24'h00_0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk(bresp, er);
		// one idle edge so a following call never re-raises bready at once
		@(posedge clk);
	end
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] ed,
		input logic [1:0] er);
	begin
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rdata, {24'h00_0000, ed});
		chk(rresp, er);
		@(posedge clk);
	end
	endtask
	task automatic count_ticks(input int n);
	begin
		cnt = '{default: 32'h0000_0000};
		repeat (n)
		begin
			@(posedge clk);
			for (int i = 0; i < 6; i++)
				cnt[i] += tk[i];
		end
	end
	endtask
	// ==========================================
	// scenarios
	task automatic t_regs;
	begin
		rst <= 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(A_CTL, 8'h00, OK);
		rd(A_T0, 8'h00, OK);
		rd(A_ALT, 8'h00, OK);
		wr(A_CTL, 8'ha5, OK);
		rd(A_CTL, 8'ha5, OK);
		wr(A_T0, 8'h3c, OK);
		rd(A_T0, 8'h3c, OK);
		// a write with lane 0 off must leave the byte alone
		strb <= 4'h0;
		wr(A_T0, 8'h77, OK);
		strb <= 4'h1;
		rd(A_T0, 8'h3c, OK);
		wr(12'h100, 8'h55, ER);
		rd(12'h100, 8'h00, ER);
	end
	endtask
	task automatic t_presc;
	int div [3];
	begin
		div = '{2, 3, 4};
		for (int c = 0; c < 3; c++)
		begin
			wr(A_CTL, 8'h08 | c[7:0], OK);
			repeat (8) @(posedge clk);
			count_ticks(12);
			chk_ticks(12 / div[c], 12, 1, 1, 1, 1);
		end
		wr(A_CTL, 8'hf4, OK);
		repeat (8) @(posedge clk);
		count_ticks(12);
		chk_ticks(12, 6, 12, 12, 12, 12);
	end
	endtask
	task automatic t_ext;
	begin
		ext_run <= 1'b1;
		wr(A_CTL, 8'h03, OK);
		wr(A_ALT, 8'h03, OK);
		repeat (80) @(posedge clk);
		count_ticks(640);
		chk_ticks(10, 10, 10, 10, 10, 10);
		ext_run <= 1'b0;
		repeat (20) @(posedge clk);
		count_ticks(200);
		chk_ticks(0, 0, 0, 0, 0, 0);
		wr(A_ALT, 8'h00, OK);
		repeat (20) @(posedge clk);
		count_ticks(48);
		chk_ticks(0, 0, 4, 4, 4, 4);
	end
	endtask
	task automatic t_count;
	logic [7:0] v;
	begin
		wr(A_CTL, 8'h04, OK);
		wr(A_T0, 8'hf0, OK);
		wr(A_ALT, 8'h04, OK);
		@(posedge clk);
		v = cnt0;
		repeat (20) @(posedge clk);
		chk(cnt0, 8'(v + 8'h14));
		wr(A_ALT, 8'h00, OK);
		repeat (2) @(posedge clk);
		v = cnt0;
		repeat (20) @(posedge clk);
		chk(cnt0, v);
	end
	endtask
	initial
	begin
		t_regs;
		t_presc;
		t_ext;
		t_count;
		t_regs;
		finish_test;
	end
endmodule
`default_nettype wire
